/* hw/rcs_reset_clock_ctrl.sv */
// Reset merging and system clock source control with an AXI4-Lite register slave.
// Assumes aclk is the fast clock, lf_tick marks a slow-clock edge in the aclk domain,
// and the core, watchdog and wake logic drive their inputs synchronously to aclk.
//
// Function
// - Four reset sources; trap, watchdog and clock fault count as malfunction resets.
// - A malfunction request holds internal reset for at most 24 fast periods (here a request held k cycles holds it k+23).
// - Power-up may give one internal reset of up to 24 fast periods.
// - Reset loads the vector address and clears interrupt enables and latches.
// - Reset clears the timing generator dividers and keeps the watchdog enabled.
// - Reset pin low for 12 fast periods applies reset and initialises state.
// - Pin high releases reset and starts from the vector at the top two bytes.
// - Fetch from special, buffer or selected RAM area raises a trap reset.
// - Trap answer selects reset or interrupt; the trapped area is selectable.
// - Illegal oscillator enable clears give a clock reset; oscillators keep running (here the reset reload turns the slow oscillator off).
// - Reset pin exits slow operation; release starts in single fast-clock run.
// - After clearing clock select the core stays on slow clock until synchronised.
// - Release from low-power clears the halt bits and resumes the previous mode.
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module rcs_reset_clock_ctrl
   import rcs_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter logic [15:0] SFR_LO = 16'h0000,
   parameter logic [15:0] SFR_HI = 16'h003F,
   parameter logic [15:0] RAM_LO = 16'h0040,
   parameter logic [15:0] RAM_HI = 16'h083F,
   parameter logic [15:0] DBR_LO = 16'h0F80,
   parameter logic [15:0] DBR_HI = 16'h0FFF
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic rst_pin_n,
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_addr,
   input wire logic wdt_reset_req,
   input wire logic wake_event,
   input wire logic lf_tick,
   output logic core_rst_r,
   output logic vector_load_r,
   output logic [15:0] vector_addr_r,
   output logic int_ctrl_clear_r,
   output logic tg_clear_r,
   output logic trap_int_r,
   output logic wdt_enable,
   output logic hf_osc_en,
   output logic lf_osc_en,
   output logic clk_sel_lf_r,
   output logic idle,
   output logic tg_halt
);

   // Refuse settings the decoder and trap compare cannot serve.
   if (ADDR_W < 4) begin : g_bad_addr
      $error("rcs_reset_clock_ctrl: ADDR_W must be at least 4");
   end
   if (SFR_LO > SFR_HI || RAM_LO > RAM_HI || DBR_LO > DBR_HI) begin : g_bad_area
      $error("rcs_reset_clock_ctrl: trap area bounds are reversed");
   end

   logic pin_n_s;
   logic [3:0] ext_cnt_r;
   logic [3:0] ext_cnt_nxt;
   logic [4:0] malf_cnt_r;
   logic [4:0] malf_cnt_nxt;
   logic core_rst_nxt;
   logic [7:0] sys_ctrl_r;
   logic [7:0] sys_ctrl_nxt;
   logic [7:0] wdt_ctrl_r;
   logic [7:0] wdt_ctrl_nxt;
   logic [3:0] rst_stat_r;
   logic [3:0] rst_stat_nxt;
   logic aw_got_r;
   logic w_got_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [7:0] w_data_r;
   logic w_lane0_r;
   logic aw_got_nxt;
   logic w_got_nxt;
   logic bvalid_nxt;
   logic rvalid_nxt;
   rcs_mode_e mode;

   // The reset pin is asynchronous, so it passes the filtered synchroniser first.
   rcs_sync3 #(
      .RESET_VAL(1'b1)
   ) u_pin_sync (
      .clk(aclk),
      .rst_n(aresetn),
      .din(rst_pin_n),
      .dout(pin_n_s)
   );

   // A low pin counts up and saturates; reset applies once the minimum low time is seen.
   wire ext_done = (ext_cnt_r == EXT_CNT_DONE);
   assign ext_cnt_nxt = pin_n_s ? 4'h0 : (ext_done ? ext_cnt_r : ext_cnt_r + 4'h1);
   wire ext_active = (ext_cnt_nxt == EXT_CNT_DONE);

   // Address trap compare on every instruction fetch outside reset.
   wire in_sfr = (fetch_addr >= SFR_LO) && (fetch_addr <= SFR_HI);
   wire in_ram = (fetch_addr >= RAM_LO) && (fetch_addr <= RAM_HI);
   wire in_dbr = (fetch_addr >= DBR_LO) && (fetch_addr <= DBR_HI);
   wire ram_trap = in_ram && wdt_ctrl_r[WC_TRAP_RAM_BIT];
   wire trap_hit = fetch_valid && !core_rst_r && (in_sfr || in_dbr || ram_trap);
   wire trap_rst_req = trap_hit && wdt_ctrl_r[WC_TRAP_RST_BIT];
   wire trap_int_nxt = trap_hit && !wdt_ctrl_r[WC_TRAP_RST_BIT];

   // AXI handshakes and write decode; a write commits once address and data are both held.
   wire aw_hs = s_axi_awvalid && s_axi_awready;
   wire w_hs = s_axi_wvalid && s_axi_wready;
   wire ar_hs = s_axi_arvalid && s_axi_arready;
   wire wr_commit = aw_got_r && w_got_r && !s_axi_bvalid;
   wire [7:0] wr_word = 8'({aw_addr_r[ADDR_W-1:2], 2'h0});
   wire wr_hi_zero = (aw_addr_r >> 8) == '0;
   wire wr_ok_addr = wr_hi_zero && ((wr_word == REG_SYS_CTRL) || (wr_word == REG_WDT_CTRL) ||
                     (wr_word == REG_RST_STAT) || (wr_word == REG_CLK_STAT));
   wire wr_lane = wr_commit && wr_hi_zero && w_lane0_r;
   wire wr_sys = wr_lane && (wr_word == REG_SYS_CTRL);
   wire wr_wdt = wr_lane && (wr_word == REG_WDT_CTRL);
   wire wr_stat = wr_lane && (wr_word == REG_RST_STAT);

   // A write that would leave the clock chosen by the register's clock select bit without its oscillator is refused
   // and turned into a clock reset, whose reload keeps the fast oscillator on and stops the slow one.
   wire new_hf = w_data_r[SC_HF_EN_BIT];
   wire new_lf = w_data_r[SC_LF_EN_BIT];
   wire cur_sel = sys_ctrl_r[SC_CLK_SEL_BIT];
   wire clk_fault = wr_sys && ((!new_hf && !new_lf) || (!new_hf && !cur_sel) ||
                    (!new_lf && cur_sel));

   // Malfunction sources reload the stretch counter, so a held request keeps reset on.
   wire malf_req = trap_rst_req || wdt_reset_req || clk_fault;
   assign malf_cnt_nxt = malf_req ? MALF_CNT_LOAD :
                         ((malf_cnt_r != 5'h0) ? malf_cnt_r - 5'h1 : 5'h0);
   assign core_rst_nxt = ext_active || (malf_cnt_nxt != 5'h0);

   // Control bits load their reset values under internal reset; wake clears the halt bits.
   wire [7:0] sys_wr = (sys_ctrl_r & ~SC_WR_MASK) | (w_data_r & SC_WR_MASK);
   wire [7:0] sys_after_wr = (wr_sys && !clk_fault) ? sys_wr : sys_ctrl_r;
   wire [7:0] halt_clr = wake_event ? ~(8'h01 << SC_IDLE_BIT | 8'h01 << SC_TG_HALT_BIT) : 8'hFF;
   assign sys_ctrl_nxt = core_rst_r ? SYS_CTRL_RST : (sys_after_wr & halt_clr);
   wire [7:0] wdt_wr = (wdt_ctrl_r & ~WC_WR_MASK) | (w_data_r & WC_WR_MASK);
   assign wdt_ctrl_nxt = core_rst_r ? WDT_CTRL_RST : (wr_wdt ? wdt_wr : wdt_ctrl_r);

   // Cause flags: a new event in the clearing cycle survives the write-one-to-clear.
   wire [3:0] stat_set = {clk_fault, wdt_reset_req, trap_rst_req, ext_active};
   wire [3:0] stat_clr = wr_stat ? w_data_r[3:0] : 4'h0;
   assign rst_stat_nxt = (rst_stat_r & ~stat_clr) | stat_set;

   // Outside internal reset the selected clock moves only on a slow-clock edge, and only toward a running
   // oscillator, which keeps the switch free of runt pulses in both directions.
   wire sel_target = sys_ctrl_r[SC_CLK_SEL_BIT];
   wire target_on = sel_target ? sys_ctrl_r[SC_LF_EN_BIT] : sys_ctrl_r[SC_HF_EN_BIT];
   wire sel_move = lf_tick && target_on && (sel_target != clk_sel_lf_r);

   // Mode as software sees it, from the clock actually in use.
   assign mode = !clk_sel_lf_r ? (sys_ctrl_r[SC_LF_EN_BIT] ? MODE_DUAL_FAST : MODE_SINGLE_FAST) :
                 (sys_ctrl_r[SC_HF_EN_BIT] ? MODE_LOW_OSC_ON : MODE_LOW_OSC_OFF);

   // Read decode; unmapped words read zero with an error response.
   wire [7:0] rd_word = 8'({s_axi_araddr[ADDR_W-1:2], 2'h0});
   wire rd_hi_zero = (s_axi_araddr >> 8) == '0;
   wire rd_sys = rd_hi_zero && (rd_word == REG_SYS_CTRL);
   wire rd_wdt = rd_hi_zero && (rd_word == REG_WDT_CTRL);
   wire rd_rst = rd_hi_zero && (rd_word == REG_RST_STAT);
   wire rd_clk = rd_hi_zero && (rd_word == REG_CLK_STAT);
   wire [7:0] clk_stat = {4'h0, mode, clk_sel_lf_r, core_rst_r};
   wire [7:0] rd_byte = rd_sys ? sys_ctrl_r : rd_wdt ? wdt_ctrl_r :
                        rd_rst ? {4'h0, rst_stat_r} : rd_clk ? clk_stat : 8'h00;
   wire rd_ok = rd_sys || rd_wdt || rd_rst || rd_clk;

   // Channel state: one write and one read in flight; readies drop while an answer waits.
   assign aw_got_nxt = (aw_got_r || aw_hs) && !wr_commit;
   assign w_got_nxt = (w_got_r || w_hs) && !wr_commit;
   assign bvalid_nxt = wr_commit || (s_axi_bvalid && !s_axi_bready);
   assign rvalid_nxt = ar_hs || (s_axi_rvalid && !s_axi_rready);

   // Write channel registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         aw_got_r <= aw_got_nxt;
         w_got_r <= w_got_nxt;
         s_axi_awready <= !aw_got_nxt && !bvalid_nxt;
         s_axi_wready <= !w_got_nxt && !bvalid_nxt;
         s_axi_bvalid <= bvalid_nxt;
         if (wr_commit) begin
            s_axi_bresp <= wr_ok_addr ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // Write payload holding; contents matter only while the matching flag is set.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr_r <= '0;
         w_data_r <= 8'h00;
         w_lane0_r <= 1'b0;
      end else begin
         if (aw_hs) begin
            aw_addr_r <= s_axi_awaddr;
         end
         if (w_hs) begin
            w_data_r <= s_axi_wdata[7:0];
            w_lane0_r <= s_axi_wstrb[0];
         end
      end
   end

   // Read channel registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= !rvalid_nxt;
         s_axi_rvalid <= rvalid_nxt;
         if (ar_hs) begin
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // Reset generation; bus reset starts a full stretch, standing in for power-up.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_cnt_r <= 4'h0;
         malf_cnt_r <= MALF_CNT_LOAD;
         core_rst_r <= 1'b1;
         vector_load_r <= 1'b0;
         vector_addr_r <= RESET_VECTOR;
         int_ctrl_clear_r <= 1'b1;
         tg_clear_r <= 1'b1;
         trap_int_r <= 1'b0;
      end else begin
         ext_cnt_r <= ext_cnt_nxt;
         malf_cnt_r <= malf_cnt_nxt;
         core_rst_r <= core_rst_nxt;
         vector_load_r <= core_rst_r && !core_rst_nxt;
         vector_addr_r <= RESET_VECTOR;
         int_ctrl_clear_r <= core_rst_nxt;
         tg_clear_r <= core_rst_nxt;
         trap_int_r <= trap_int_nxt;
      end
   end

   // Control and status registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sys_ctrl_r <= SYS_CTRL_RST;
         wdt_ctrl_r <= WDT_CTRL_RST;
         rst_stat_r <= RST_STAT_RST;
         clk_sel_lf_r <= 1'b0;
      end else begin
         sys_ctrl_r <= sys_ctrl_nxt;
         wdt_ctrl_r <= wdt_ctrl_nxt;
         rst_stat_r <= rst_stat_nxt;
         if (core_rst_r) begin
            clk_sel_lf_r <= 1'b0;
         end else if (sel_move) begin
            clk_sel_lf_r <= sel_target;
         end
      end
   end

   // Control outputs come straight from the control register flip-flops.
   assign hf_osc_en = sys_ctrl_r[SC_HF_EN_BIT];
   assign lf_osc_en = sys_ctrl_r[SC_LF_EN_BIT];
   assign idle = sys_ctrl_r[SC_IDLE_BIT];
   assign tg_halt = sys_ctrl_r[SC_TG_HALT_BIT];
   assign wdt_enable = wdt_ctrl_r[WC_WDT_EN_BIT];

endmodule : rcs_reset_clock_ctrl
`default_nettype wire

/* hw/rcs_pkg.sv */
// Constants, field positions and reset values of the reset and clock switch block.
// Assumes aclk is the high-frequency system clock and that registers sit in byte lane 0.
package rcs_pkg;

   // Register byte offsets on the AXI4-Lite bus.
   localparam logic [7:0] REG_SYS_CTRL = 8'h00;
   localparam logic [7:0] REG_WDT_CTRL = 8'h04;
   localparam logic [7:0] REG_RST_STAT = 8'h08;
   localparam logic [7:0] REG_CLK_STAT = 8'h0C;

   // Fields of system_control_two.
   localparam int SC_HF_EN_BIT = 7;
   localparam int SC_LF_EN_BIT = 6;
   localparam int SC_CLK_SEL_BIT = 5;
   localparam int SC_IDLE_BIT = 4;
   localparam int SC_TG_HALT_BIT = 2;
   localparam logic [7:0] SC_WR_MASK = 8'hF4;
   localparam logic [7:0] SYS_CTRL_RST = 8'h80;

   // Fields of watchdog_control_one.
   localparam int WC_WDT_EN_BIT = 7;
   localparam int WC_TRAP_RAM_BIT = 2;
   localparam int WC_TRAP_RST_BIT = 1;
   localparam logic [7:0] WC_WR_MASK = 8'h86;
   localparam logic [7:0] WDT_CTRL_RST = 8'h82;

   // Reset cause flags.
   localparam int RS_EXT_BIT = 0;
   localparam int RS_TRAP_BIT = 1;
   localparam int RS_WDT_BIT = 2;
   localparam int RS_CLK_BIT = 3;
   localparam logic [3:0] RST_STAT_RST = 4'h0;

   // Reset vector and bus answers.
   localparam logic [15:0] RESET_VECTOR = 16'hFFFE;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Times in high-frequency clock periods, and their cycle counts on aclk.
   localparam int CLK_PERIOD_NS = 40;
   localparam int FC_PER_ACLK = 1;
   localparam int EXT_RST_MIN_FC = 12;
   localparam int MALF_RST_MAX_FC = 24;
   localparam int EXT_RST_MIN_CYC = (EXT_RST_MIN_FC + FC_PER_ACLK - 1) / FC_PER_ACLK;
   localparam int MALF_RST_CYC = MALF_RST_MAX_FC / FC_PER_ACLK;
   localparam logic [4:0] MALF_CNT_LOAD = 5'(MALF_RST_CYC);
   localparam logic [3:0] EXT_CNT_DONE = 4'(EXT_RST_MIN_CYC);

   // Operating modes as seen by software.
   typedef enum logic [1:0] {
      MODE_SINGLE_FAST,
      MODE_DUAL_FAST,
      MODE_LOW_OSC_ON,
      MODE_LOW_OSC_OFF
   } rcs_mode_e;

endpackage : rcs_pkg

/* hw/rcs_sync3.sv */
// Three-stage input synchroniser with an agreement filter.
// Assumes din is asynchronous to clk; dout moves only when stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module rcs_sync3 #(
   parameter logic RESET_VAL = 1'b1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic din,
   output logic dout
);

   logic q1_r;
   logic q2_r;
   logic q3_r;

   // The first stage is read only by the second; the filter looks at stages two and three.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q1_r <= RESET_VAL;
         q2_r <= RESET_VAL;
         q3_r <= RESET_VAL;
         dout <= RESET_VAL;
      end else begin
         q1_r <= din;
         q2_r <= q1_r;
         q3_r <= q2_r;
         if (q2_r == q3_r) begin
            dout <= q3_r;
         end
      end
   end

endmodule : rcs_sync3
`default_nettype wire

/* dv/rcs_far_model.sv */
// Far-side model: the reset pin source and the slow-clock edge marker.
// Assumes the bench calls pin_pulse by hierarchical name and drives tick_run.
`timescale 1ns/1ns
`default_nettype none
module rcs_far_model (
   input wire logic aclk,
   input wire logic tick_run,
   output logic rst_pin_n,
   output logic lf_tick
);
   logic [2:0] div_r = 3'h0;
   // The pin idles high because of its pull-up.
   initial begin
      rst_pin_n = 1'h1;
      lf_tick = 1'h0;
   end
   // One slow edge every eighth fast cycle; it stands still while tick_run is low.
   always @(posedge aclk) begin
      div_r <= div_r + 3'h1;
      lf_tick <= tick_run && (div_r == 3'h7);
   end
   // A short pulse is stretched, because a pin low for less than the minimum may be ignored.
   task automatic pin_pulse(input int n);
      @(posedge aclk);
      rst_pin_n <= 1'h0;
      repeat ((n < 12) ? 12 : n) @(posedge aclk);
      rst_pin_n <= 1'h1;
   endtask : pin_pulse
endmodule : rcs_far_model
`default_nettype wire

/* dv/rcs_reset_clock_ctrl_asserts.sv */
// Checker of the reset and clock switch block, bound to its top module.
// Assumes one clock domain, aclk, with aresetn as its synchronous reset.
`timescale 1ns/1ns
`default_nettype none
module rcs_reset_clock_ctrl_asserts
   import rcs_pkg::*;
#(
   parameter logic [15:0] SFR_LO = 16'h0000,
   parameter logic [15:0] SFR_HI = 16'h003F,
   parameter logic [15:0] RAM_LO = 16'h0040,
   parameter logic [15:0] RAM_HI = 16'h083F,
   parameter logic [15:0] DBR_LO = 16'h0F80,
   parameter logic [15:0] DBR_HI = 16'h0FFF
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic rst_pin_n,
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_addr,
   input wire logic wdt_reset_req,
   input wire logic wake_event,
   input wire logic lf_tick,
   input wire logic core_rst_r,
   input wire logic vector_load_r,
   input wire logic [15:0] vector_addr_r,
   input wire logic int_ctrl_clear_r,
   input wire logic tg_clear_r,
   input wire logic trap_int_r,
   input wire logic wdt_enable,
   input wire logic hf_osc_en,
   input wire logic lf_osc_en,
   input wire logic clk_sel_lf_r,
   input wire logic idle,
   input wire logic tg_halt
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // RAM is counted as trappable always, since its select bit is not visible here.
   wire logic sfr_hit = fetch_addr >= SFR_LO && fetch_addr <= SFR_HI;
   wire logic dbr_hit = fetch_addr >= DBR_LO && fetch_addr <= DBR_HI;
   wire logic any_hit = sfr_hit || dbr_hit || (fetch_addr >= RAM_LO && fetch_addr <= RAM_HI);
   sequence pin_held_low;
      (!rst_pin_n) [*8] ##1 (!rst_pin_n) [*8] ##1 (!rst_pin_n) [*4];
   endsequence
   sequence stretch_done;
      core_rst_r ##22 core_rst_r ##[1:2] !core_rst_r;
   endsequence
   chk_wdt_start: assert property (wdt_reset_req |=> core_rst_r)
      else $error("watchdog request gave no internal reset");
   chk_malf_len: assert property ($fell(wdt_reset_req) |-> stretch_done)
      else $error("malfunction reset length wrong");
   chk_clear_follow: assert property (int_ctrl_clear_r == core_rst_r
      && tg_clear_r == core_rst_r)
      else $error("clear outputs differ from internal reset");
   chk_vector_fixed: assert property (vector_addr_r == RESET_VECTOR)
      else $error("vector address wrong");
   chk_vector_pulse: assert property ($fell(core_rst_r) |-> ##[0:1] vector_load_r)
      else $error("no vector load after reset release");
   chk_trap_answer: assert property (fetch_valid && !core_rst_r && (sfr_hit || dbr_hit)
      |=> trap_int_r || core_rst_r)
      else $error("trapped fetch gave neither reset nor interrupt");
   chk_trap_cause: assert property (trap_int_r |-> $past(fetch_valid) && $past(any_hit))
      else $error("trap interrupt without trapped fetch");
   chk_reset_state: assert property (core_rst_r
      |=> wdt_enable && hf_osc_en && !lf_osc_en && !idle && !tg_halt)
      else $error("reset state not loaded");
   chk_pin_apply: assert property (pin_held_low |-> core_rst_r)
      else $error("long pin low gave no reset");
   chk_pin_release: assert property ($rose(rst_pin_n) |-> ##[1:8] !core_rst_r)
      else $error("reset not released after pin high");
   chk_sel_tick: assert property ($changed(clk_sel_lf_r)
      |-> $past(lf_tick) || $past(core_rst_r) || core_rst_r)
      else $error("clock switched off a slow edge");
   chk_sel_rise: assert property ($rose(clk_sel_lf_r) |-> lf_osc_en)
      else $error("switched to a stopped slow oscillator");
   chk_sel_fall: assert property ($fell(clk_sel_lf_r) && !core_rst_r
      && !$past(core_rst_r) |-> hf_osc_en)
      else $error("switched to a stopped fast oscillator");
   chk_wake_clear: assert property (wake_event |=> !idle && !tg_halt)
      else $error("wake left halt bits set");
endmodule : rcs_reset_clock_ctrl_asserts
bind rcs_reset_clock_ctrl rcs_reset_clock_ctrl_asserts #(.SFR_LO(SFR_LO), .SFR_HI(SFR_HI),
   .RAM_LO(RAM_LO), .RAM_HI(RAM_HI), .DBR_LO(DBR_LO), .DBR_HI(DBR_HI)) u_chk (.aclk, .aresetn,
   .rst_pin_n, .fetch_valid, .fetch_addr, .wdt_reset_req, .wake_event, .lf_tick, .core_rst_r,
   .vector_load_r, .vector_addr_r, .int_ctrl_clear_r, .tg_clear_r, .trap_int_r, .wdt_enable,
   .hf_osc_en, .lf_osc_en, .clk_sel_lf_r, .idle, .tg_halt);
`default_nettype wire

/* dv/rcs_reset_clock_ctrl_bench.sv */
// Self-checking bench of the reset and clock switch block with reference counts.
// Assumes the far-side model supplies the reset pin and the slow-clock edge marker.
`timescale 1ns/1ns
`default_nettype none
module reset_and_clock_switch_ctrl_bench
   import rcs_pkg::*;
   ;
   logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, fetch_valid = 1'h0;
   logic wdt_reset_req = 1'h0, wake_event = 1'h0, tick_run = 1'h1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, lfsr = 32'h3C46CCCB;
   logic [3:0] s_axi_wstrb = 4'hF, stat_m = 4'h0;
   logic [15:0] fetch_addr = 16'h0000, vector_addr_r;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rst_pin_n;
   logic lf_tick, core_rst_r, vector_load_r, int_ctrl_clear_r, tg_clear_r, trap_int_r;
   logic wdt_enable, hf_osc_en, lf_osc_en, clk_sel_lf_r, idle, tg_halt, t;
   int err_count = 0, comparisons = 0, hi_cnt = 0, vl_cnt = 0, base, k;
   localparam logic [15:0] DBR_LO_ADDR = 16'h0F80;
   rcs_reset_clock_ctrl DUT (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
      .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
      .s_axi_rdata, .s_axi_rresp, .rst_pin_n, .fetch_valid, .fetch_addr, .wdt_reset_req,
      .wake_event, .lf_tick, .core_rst_r, .vector_load_r, .vector_addr_r, .int_ctrl_clear_r,
      .tg_clear_r, .trap_int_r, .wdt_enable, .hf_osc_en, .lf_osc_en, .clk_sel_lf_r, .idle,
      .tg_halt);
   rcs_far_model far (.aclk, .tick_run, .rst_pin_n, .lf_tick);
   // Clock, and a count of internal reset cycles that the scenarios difference.
   always #20 aclk = ~aclk;
   always @(posedge aclk) hi_cnt <= hi_cnt + ((core_rst_r === 1'h1) ? 1 : 0);
   // Every release of internal reset must give exactly one vector load pulse.
   always @(posedge aclk) vl_cnt <= vl_cnt + ((vector_load_r === 1'h1) ? 1 : 0);
   function automatic logic [31:0] next_rand(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : next_rand
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_of_test
   // Address and data go out together and each drops once it has been taken.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      resp = s_axi_bresp;
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      resp = s_axi_rresp;
      chk(s_axi_rdata, exp);
   endtask : rchk
   // Bounded waits on the internal reset and on the clock actually in use.
   task automatic quiet();
      repeat (3) @(posedge aclk);
      for (int i = 0; i < 200 && core_rst_r !== 1'h0; i++) @(posedge aclk);
      repeat (3) @(posedge aclk);
   endtask : quiet
   task automatic wait_sel(input logic v);
      for (int i = 0; i < 200 && clk_sel_lf_r !== v; i++) @(posedge aclk);
   endtask : wait_sel
   // A one-cycle fetch; the trap interrupt is looked at once the next edge has landed.
   task automatic fetch(input logic [15:0] a);
      @(posedge aclk);
      fetch_valid <= 1'h1;
      fetch_addr <= a;
      @(posedge aclk);
      fetch_valid <= 1'h0;
      #1 t = trap_int_r;
   endtask : fetch
   task automatic fault(input logic [7:0] v);
      base = hi_cnt;
      wr(REG_SYS_CTRL, v);
      quiet();
      chk(hi_cnt - base, MALF_RST_CYC);
      rchk(REG_SYS_CTRL, SYS_CTRL_RST);
   endtask : fault
   task automatic to_slow();
      wr(REG_SYS_CTRL, 8'hC0);
      repeat (16) @(posedge aclk);
      wr(REG_SYS_CTRL, 8'hE0);
      wait_sel(1'h1);
   endtask : to_slow
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      base = hi_cnt;
      quiet();
      chk({31'h0, (hi_cnt - base) inside {[1:25]}}, 32'h1);
      rchk(REG_SYS_CTRL, SYS_CTRL_RST);
      rchk(REG_WDT_CTRL, WDT_CTRL_RST);
      rchk(REG_CLK_STAT, 32'h0);
      rchk(8'h10, 32'h0);
      chk(resp, RESP_SLVERR);
      // Watchdog bursts of random length; the stretch counts from the last request.
      for (int i = 0; i < 3; i++) begin
         lfsr = next_rand(lfsr);
         k = 1 + lfsr[1:0];
         base = hi_cnt;
         @(posedge aclk);
         wdt_reset_req <= 1'h1;
         repeat (k) @(posedge aclk);
         wdt_reset_req <= 1'h0;
         quiet();
         chk(hi_cnt - base, k + MALF_RST_CYC - 1);
      end
      stat_m[RS_WDT_BIT] = 1'h1;
      fault(8'h00);
      fault(8'h40);
      tick_run <= 1'h0;
      wr(REG_SYS_CTRL, 8'hC0);
      wr(REG_SYS_CTRL, 8'hE0);
      repeat (10) @(posedge aclk);
      chk(clk_sel_lf_r, 1'h0);
      tick_run <= 1'h1;
      wait_sel(1'h1);
      rchk(REG_CLK_STAT, 32'hA);
      wr(REG_SYS_CTRL, 8'h60);
      rchk(REG_CLK_STAT, 32'hE);
      wr(REG_SYS_CTRL, 8'hE0);
      tick_run <= 1'h0;
      wr(REG_SYS_CTRL, 8'hC0);
      repeat (10) @(posedge aclk);
      chk(clk_sel_lf_r, 1'h1);
      tick_run <= 1'h1;
      wait_sel(1'h0);
      rchk(REG_CLK_STAT, 32'h4);
      to_slow();
      fault(8'hA0);
      stat_m[RS_CLK_BIT] = 1'h1;
      // Trap answers: interrupt for the special area, RAM only when selected, then reset from the buffer area.
      wr(REG_WDT_CTRL, 8'h80);
      lfsr = next_rand(lfsr);
      fetch({10'h0, lfsr[5:0]});
      chk(t, 1'h1);
      fetch(16'h0100);
      chk(t, 1'h0);
      wr(REG_WDT_CTRL, 8'h84);
      fetch(16'h0100);
      chk(t, 1'h1);
      wr(REG_WDT_CTRL, 8'h82);
      base = hi_cnt;
      fetch(DBR_LO_ADDR + {9'h0, lfsr[12:6]});
      quiet();
      chk(hi_cnt - base, MALF_RST_CYC);
      stat_m[RS_TRAP_BIT] = 1'h1;
      to_slow();
      wr(REG_SYS_CTRL, 8'h60);
      far.pin_pulse(20);
      quiet();
      rchk(REG_CLK_STAT, 32'h0);
      stat_m[RS_EXT_BIT] = 1'h1;
      rchk(REG_RST_STAT, {28'h0, stat_m});
      wr(REG_RST_STAT, 8'h0F);
      rchk(REG_RST_STAT, 32'h0);
      wr(REG_SYS_CTRL, 8'h94);
      rchk(REG_SYS_CTRL, 32'h94);
      chk({hf_osc_en, lf_osc_en, idle, tg_halt, wdt_enable}, 5'h17);
      @(posedge aclk);
      wake_event <= 1'h1;
      @(posedge aclk);
      wake_event <= 1'h0;
      rchk(REG_SYS_CTRL, 32'h80);
      chk({hf_osc_en, lf_osc_en, idle, tg_halt, wdt_enable}, 5'h11);
      // One power-up, three watchdog, three clock fault, one trap and one pin reset.
      chk(vl_cnt, 9);
      end_of_test();
   end
   // A hang is cut short well past the expected run of a few hundred cycles.
   initial begin
      repeat (20000) @(posedge aclk);
      err_count++;
      end_of_test();
   end
endmodule : reset_and_clock_switch_ctrl_bench
`default_nettype wire
